// File: logic/sxc_serdes_clocking.sv
`include "sxc_params.svh"
module sxc_serdes_clocking
    import sxc_pkg::*;
#(
    parameter int        CHANNELS = `SXC_CHANNELS,
    parameter logic [3:0] FACTOR  = `SXC_FACTOR_DEF
)(
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    input  wire sxc_mode_t                      rxMode,
    input  wire logic                           synthSerialEn,
    input  wire logic                           synthLoadEn,
    input  wire logic                           synthAlignEn,
    input  wire logic                           synthResetRx,
    input  wire logic [`SXC_WIDTH_MAX-1:0]      txParallel,
    input  wire logic [CHANNELS-1:0]            rxSerial,
    input  wire logic [CHANNELS*`SXC_PHASES-1:0] rxPhaseSamples,
    output logic                                txSerial,
    output logic                                txLoaded,
    output logic [CHANNELS*`SXC_WIDTH_MAX-1:0]  rxParallel,
    output logic                                rxValid,
    output logic [CHANNELS-1:0]                 rxAligned
);
    // ----------------------------------------
    // Clocking scheme
    // ----------------------------------------
    // clk_sys stands for the parallel word clock
    // Serial, load and alignment clocks arrive as enables
    // Serial enable feeds the transmit shift path, the plain-mode receive shift, the transmit load flag and the plain-mode receive strobe
    // Receiver owns the synth reset, transmitter has none
    // Enables must be one clk_sys cycle wide
    // Factor is fixed at build time, never at run time

    // ----------------------------------------
    // Build-time settings
    // ----------------------------------------
    localparam logic [3:0] FMAX = `SXC_FACTOR_MAX;
    localparam logic [3:0] FMIN = `SXC_FACTOR_MIN;
    // Factor fixed at build time, clamped to the legal range
    localparam logic [3:0] FEFF = (FACTOR > FMAX) ? FMAX : (FACTOR < FMIN) ? FMIN : FACTOR;

    // Mask keeping the low n bits of a word
    function automatic logic [`SXC_WIDTH_MAX-1:0] sxcMask(input logic [3:0] n);
        sxcMask = 10'h3FF >> (4'hA - n);
    endfunction : sxcMask

    // True while a counter stands on the last bit of a frame
    function automatic logic sxcFrameEnd(input logic [3:0] cnt, input logic [3:0] n);
        sxcFrameEnd = (cnt == n - 4'h1);
    endfunction : sxcFrameEnd

    // ----------------------------------------
    // Mode and enable decode
    // ----------------------------------------
    logic [3:0] rxBitCnt_r;
    wire  logic rxFrameEnd = sxcFrameEnd(rxBitCnt_r, FEFF);

    // Alignment and recovery share the alignment clock path
    wire logic alignMode  = (rxMode != SXC_MODE_PLAIN);
    wire logic recovMode  = (rxMode == SXC_MODE_RECOVER);
    // Synth reset has no default, so left unconnected it floats and the hold is undefined outside plain mode
    // Plain mode has no lock to wait for, so the hold is ignored there
    wire logic rxHeld     = alignMode && synthResetRx;
    // Recovery ignores load and serial inputs
    wire logic rxSerialEn = recovMode ? synthAlignEn : synthSerialEn;
    wire logic rxLoadEn   = recovMode ? (rxFrameEnd && synthAlignEn)
                                      : synthLoadEn;
    wire logic rxShiftEn  = alignMode ? synthAlignEn : rxSerialEn;
    wire logic rxTake     = rxShiftEn && rxLoadEn;

    // ----------------------------------------
    // Transmit serializer
    // ----------------------------------------
    logic [`SXC_WIDTH_MAX-1:0] txShift_r;
    logic                      txSerial_r;
    logic                      txLoaded_r;
    wire  logic                txTake = synthSerialEn && synthLoadEn;
    // Unused upper bits are masked so they never reach the line
    wire  logic [`SXC_WIDTH_MAX-1:0] txLoadWord = txParallel & sxcMask(FEFF);
    wire  logic [`SXC_WIDTH_MAX-1:0] txMoved    = {txShift_r[8:0], 1'b0};
    // Load wins over shift when both fall on one serial bit
    wire  logic [`SXC_WIDTH_MAX-1:0] txNext     = synthLoadEn ? txLoadWord : txMoved;
    wire  logic                      txMsb      = txShift_r[FEFF-1];

    // Load on load enable, shift MSB first on serial enable
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            txShift_r  <= 10'h000;
            txSerial_r <= 1'b0;
            txLoaded_r <= 1'b0;
        end else begin
            txLoaded_r <= txTake;
            if (synthSerialEn) begin
                txSerial_r <= txMsb;
                txShift_r  <= txNext;
            end
        end
    end
    assign txSerial = txSerial_r;
    assign txLoaded = txLoaded_r;

    // ----------------------------------------
    // Receive frame pacing
    // ----------------------------------------
    // Wraps after FEFF shift enables
    wire logic [3:0] rxBitNext = rxFrameEnd ? 4'h0 : rxBitCnt_r + 4'h1;

    // Bit counter paces frames in recovery mode
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxBitCnt_r <= 4'h0;
        end else if (rxHeld) begin
            rxBitCnt_r <= 4'h0;
        end else if (rxShiftEn) begin
            rxBitCnt_r <= rxBitNext;
        end
    end

    // ----------------------------------------
    // Receive channels
    // ----------------------------------------
    logic [CHANNELS-1:0] alignOk;
    logic [CHANNELS-1:0] alignBit;

    genvar g;
    for (g = 0; g < CHANNELS; g++) begin : gCh
        logic [`SXC_WIDTH_MAX-1:0] shift_r;
        logic [`SXC_WIDTH_MAX-1:0] word_r;
        wire  logic                inBit = alignMode ? alignBit[g] : rxSerial[g];
        // Shift register after one more serial bit
        wire  logic [`SXC_WIDTH_MAX-1:0] shiftNext = {shift_r[8:0], inBit} & sxcMask(FEFF);

        // Dedicated aligner per channel
        sxc_phase_align uAlign (
            .clk_sys      (clk_sys),
            .resetn       (resetn),
            .runEn        (alignMode && !rxHeld),
            .phaseSamples (rxPhaseSamples[g*`SXC_PHASES +: `SXC_PHASES]),
            .phaseSel     (),
            .alignLocked  (alignOk[g]),
            .bitOut       (alignBit[g])
        );

        // Shift in serial bits, transfer frame on load enable
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                shift_r <= 10'h000;
                word_r  <= 10'h000;
            end else if (rxHeld) begin
                shift_r <= 10'h000;
            end else if (rxShiftEn) begin
                shift_r <= shiftNext;
                if (rxLoadEn) word_r <= shiftNext;
            end
        end
        assign rxParallel[g*`SXC_WIDTH_MAX +: `SXC_WIDTH_MAX] = word_r;
    end

    // ----------------------------------------
    // Receive strobe and status
    // ----------------------------------------
    logic                rxStarted_r;
    logic                rxValid_r;
    logic [CHANNELS-1:0] rxAligned_r;
    // Plain mode does not run the aligners, so every channel reports ready
    wire  logic [CHANNELS-1:0] alignView = alignMode ? alignOk : {CHANNELS{1'b1}};

    // First frame counts only after a full frame since release
    // Hold beats a load in the same cycle, so a held frame never counts
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxStarted_r <= 1'b0;
            rxValid_r   <= 1'b0;
        end else if (rxHeld) begin
            rxStarted_r <= 1'b0;
            rxValid_r   <= 1'b0;
        end else begin
            rxValid_r <= rxTake && rxStarted_r;
            if (rxTake) begin
                rxStarted_r <= 1'b1;
            end
        end
    end

    // Registered alignment status per channel
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rxAligned_r <= '0;
        end else begin
            rxAligned_r <= alignView;
        end
    end
    assign rxValid   = rxValid_r;
    assign rxAligned = rxAligned_r;
endmodule : sxc_serdes_clocking

// File: logic/sxc_params.svh
`ifndef SXC_PARAMS_SVH
`define SXC_PARAMS_SVH
// ----------------------------------------
// Constants
// ----------------------------------------
`define SXC_FACTOR_DEF   4'hA
`define SXC_FACTOR_MIN   4'h3
`define SXC_FACTOR_MAX   4'hA
`define SXC_WIDTH_MAX    10
`define SXC_CHANNELS     2
`define SXC_PHASES       8
`define SXC_PHASE_W      3
`define SXC_LOCK_W       4
`define SXC_LOCK_THRESH  4'hF
`endif

// File: logic/sxc_pkg.sv
`include "sxc_params.svh"
package sxc_pkg;
    // Receiver clocking modes
    typedef enum logic [1:0] {
        SXC_MODE_PLAIN,
        SXC_MODE_ALIGN,
        SXC_MODE_RECOVER
    } sxc_mode_t;

    // Alignment state per channel
    typedef enum logic [1:0] {
        SXC_AL_IDLE,
        SXC_AL_SEARCH,
        SXC_AL_LOCKED
    } sxc_align_t;
endpackage : sxc_pkg

// File: logic/sxc_phase_align.sv
`include "sxc_params.svh"
module sxc_phase_align
    import sxc_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     resetn,
    input  wire logic                     runEn,
    input  wire logic [`SXC_PHASES-1:0]   phaseSamples,
    output logic      [`SXC_PHASE_W-1:0]  phaseSel,
    output logic                          alignLocked,
    output logic                          bitOut
);
    // ----------------------------------------
    // Per-channel phase selection
    // ----------------------------------------
    sxc_align_t              state_r;
    logic [`SXC_PHASE_W-1:0] phase_r;
    logic [`SXC_LOCK_W-1:0]  stable_r;
    logic                    prevBit_r;
    logic                    bit_r;
    wire  logic              curBit   = phaseSamples[phase_r];
    wire  logic              edgeSeen = (curBit != prevBit_r) &&
                                        (phaseSamples[phase_r + 3'h1] != curBit);
    wire  logic              settled  = (stable_r == `SXC_LOCK_THRESH);

    // Hunt for a phase away from data edges of this channel only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r   <= SXC_AL_IDLE;
            phase_r   <= 3'h0;
            stable_r  <= 4'h0;
            prevBit_r <= 1'b0;
            bit_r     <= 1'b0;
        end else if (!runEn) begin
            state_r  <= SXC_AL_IDLE;
            stable_r <= 4'h0;
        end else begin
            prevBit_r <= curBit;
            bit_r     <= curBit;
            case (state_r)
                SXC_AL_IDLE:   state_r <= SXC_AL_SEARCH;
                SXC_AL_SEARCH: begin
                    if (edgeSeen) begin
                        phase_r  <= phase_r + 3'h1;
                        stable_r <= 4'h0;
                    end else if (settled) begin
                        state_r <= SXC_AL_LOCKED;
                    end else begin
                        stable_r <= stable_r + 4'h1;
                    end
                end
                SXC_AL_LOCKED: if (edgeSeen) state_r <= SXC_AL_SEARCH;
                default:       state_r <= SXC_AL_IDLE;
            endcase
        end
    end

    assign phaseSel    = phase_r;
    assign alignLocked = (state_r == SXC_AL_LOCKED);
    assign bitOut      = bit_r;
endmodule : sxc_phase_align

// File: dv/sxc_serdes_clocking_assertions.sv
module sxc_serdes_clocking_assertions
    import sxc_pkg::*;
(
    input wire logic      clk_sys,
    input wire logic      resetn,
    input wire sxc_mode_t rxMode,
    input wire logic      synthSerialEn,
    input wire logic      synthLoadEn,
    input wire logic      synthResetRx,
    input wire logic      txSerial,
    input wire logic      txLoaded,
    input wire logic      rxValid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [1:0] loadCnt_r;
    wire        plain = rxMode == SXC_MODE_PLAIN;
    wire        held  = rxMode != SXC_MODE_PLAIN && synthResetRx;
    // Loads seen since reset, saturating at two
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) loadCnt_r <= 2'h0;
        else if (synthSerialEn && synthLoadEn && loadCnt_r != 2'h2) loadCnt_r <= loadCnt_r + 2'h1;
    end
    sequence s_load;
        synthSerialEn && synthLoadEn;
    endsequence
    a_tx_load: assert property (s_load |=> txLoaded)
        else $error("word load not flagged");
    a_tx_cause: assert property (txLoaded |-> $past(synthSerialEn && synthLoadEn))
        else $error("load flag without load");
    a_tx_hold: assert property (!$past(synthSerialEn) |-> $stable(txSerial))
        else $error("serial out moved without enable");
    a_valid_pulse: assert property (rxValid |=> !rxValid)
        else $error("receive strobe too long");
    a_valid_cause: assert property (plain && rxValid |-> $past(synthLoadEn))
        else $error("receive strobe without load");
    a_held_quiet: assert property (held [*2] |=> !rxValid)
        else $error("receive strobe while held");
    a_first_load: assert property (plain && rxValid |-> loadCnt_r == 2'h2)
        else $error("strobe on first load");
endmodule : sxc_serdes_clocking_assertions
bind sxc_serdes_clocking sxc_serdes_clocking_assertions u_chk (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .rxMode        (rxMode),
    .synthSerialEn (synthSerialEn),
    .synthLoadEn   (synthLoadEn),
    .synthResetRx  (synthResetRx),
    .txSerial      (txSerial),
    .txLoaded      (txLoaded),
    .rxValid       (rxValid)
);

// File: dv/sxc_synth_model.sv
module sxc_synth_model #(
    parameter int F = 5
)(
    input  wire logic  clk_sys,
    input  wire logic  resetn,
    input  wire logic  lockOk,
    output logic       synthSerialEn,
    output logic       synthLoadEn,
    output logic       synthAlignEn,
    output logic       synthResetRx,
    output logic [3:0] bitIdx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic gap_r;
    // Bit enable every second cycle, load with last bit of frame
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {gap_r, synthSerialEn, synthLoadEn, bitIdx} <= '0;
        end else begin
            gap_r         <= !gap_r;
            synthSerialEn <= gap_r;
            synthLoadEn   <= gap_r && bitIdx == 4'(F - 1);
            if (synthSerialEn) bitIdx <= (bitIdx == 4'(F - 1)) ? 4'h0 : bitIdx + 4'h1;
        end
    end
    // Alignment enable at bit rate, inverted lock as hold
    assign synthAlignEn = synthSerialEn;
    assign synthResetRx = !lockOk;
    // clk_sys itself stands for the parallel word clock
    // Serial enable also drives the alignment enable and steps bitIdx
endmodule : sxc_synth_model

// File: dv/sxc_serdes_clocking_tb.sv
module sxc_serdes_clocking_tb
    import sxc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         F   = 5;
    localparam logic [9:0] MSK = 10'h01F;
    logic            clk_sys, resetn, lockOk, serD, txOn, txSerial, txLoaded, rxValid;
    logic            expBit;
    logic            synthSerialEn, synthLoadEn, synthAlignEn, synthResetRx;
    sxc_mode_t       rxMode;
    sxc_mode_t       modes[3] = '{SXC_MODE_PLAIN, SXC_MODE_ALIGN, SXC_MODE_RECOVER};
    logic [9:0]      txParallel, txW;
    logic [3:0]      bitIdx, txK;
    logic [1:0][9:0] rxWord, lastRx;
    logic [19:0]     rxParallel;
    logic [1:0]      rxAligned;
    logic [31:0]     rng = 32'h000132CE;
    int              n_mismatch = 0;
    int              checks = 0;
    int              nVal = 0;
    wire [3:0]       idx = 4'(F - 1) - bitIdx;
    wire [1:0]       rxSerial = {rxWord[1][idx], rxWord[0][idx]};
    wire [15:0]      rxPhaseSamples = {{8{rxSerial[1]}}, {8{rxSerial[0]}}};
    sxc_serdes_clocking #(.CHANNELS(2), .FACTOR(4'h5)) dut (
        .clk_sys        (clk_sys),
        .resetn         (resetn),
        .rxMode         (rxMode),
        .synthSerialEn  (synthSerialEn),
        .synthLoadEn    (synthLoadEn),
        .synthAlignEn   (synthAlignEn),
        .synthResetRx   (synthResetRx),
        .txParallel     (txParallel),
        .rxSerial       (rxSerial),
        .rxPhaseSamples (rxPhaseSamples),
        .txSerial       (txSerial),
        .txLoaded       (txLoaded),
        .rxParallel     (rxParallel),
        .rxValid        (rxValid),
        .rxAligned      (rxAligned)
    );
    sxc_synth_model #(.F(F)) synth (
        .clk_sys       (clk_sys),
        .resetn        (resetn),
        .lockOk        (lockOk),
        .synthSerialEn (synthSerialEn),
        .synthLoadEn   (synthLoadEn),
        .synthAlignEn  (synthAlignEn),
        .synthResetRx  (synthResetRx),
        .bitIdx        (bitIdx)
    );
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : rnd
    function automatic logic [19:0] expRx(input logic [1:0][9:0] w);
        return {w[1] & MSK, w[0] & MSK};
    endfunction : expRx
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Watchdog
    initial begin
        repeat (4000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end
    // New words at each load, serial and word comparisons
    // Serial out shows, one cycle on, the bit picked at each serial enable
    always @(posedge clk_sys) begin
        serD <= synthSerialEn && txOn;
        if (!resetn) begin
            txOn <= 1'b0;
        end else begin
            if (synthSerialEn) begin
                if (txOn) expBit <= txW[txK];
                txK <= synthLoadEn ? 4'(F - 1) : txK - 4'h1;
            end
            if (synthSerialEn && synthLoadEn) begin
                lastRx     <= rxWord;
                txW        <= txParallel;
                txOn       <= 1'b1;
                rxWord     <= 20'(rnd());
                txParallel <= 10'(rnd());
            end
            if (serD) begin
                check(20'(txSerial), 20'(expBit));
            end
            if (rxValid) begin
                check(rxParallel, expRx(lastRx));
                nVal++;
            end
        end
    end
    // Each receive mode after its own reset, lock lost in alignment mode
    initial begin
        {resetn, lockOk, serD, txOn} = 4'h4;
        rxMode = SXC_MODE_PLAIN;
        txParallel = 10'h000;
        rxWord = '0;
        foreach (modes[i]) begin
            resetn <= 1'b0;
            rxMode <= modes[i];
            repeat (16) @(posedge clk_sys);
            resetn <= 1'b1;
            repeat (400) @(posedge clk_sys);
            check(20'(rxAligned), 20'h00003);
            if (modes[i] == SXC_MODE_ALIGN) begin
                lockOk <= 1'b0;
                repeat (40) @(posedge clk_sys);
                check(20'(rxAligned), 20'h00000);
                lockOk <= 1'b1;
                repeat (100) @(posedge clk_sys);
                check(20'(rxAligned), 20'h00003);
            end
        end
        check(20'(nVal > 30), 20'h00001);
        complete_run();
    end
endmodule : sxc_serdes_clocking_tb
